// ==== qdsc_pkg.sv ====
/*
 Constants, field layouts, reset values and state type for the quad DAC
 serial control block. Assumes nothing beyond a SystemVerilog compiler.
*/
package qdsc_pkg;

    localparam int CHANNELS = 4;
    localparam int CODE_BITS = 12;
    localparam int WORD_BITS = 16;
    localparam int FIFO_WIDTH = CHANNELS + WORD_BITS;
    localparam int FIFO_DEPTH = 32;

    // Fixed upper five bits of the slave address
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h03;

    // Bit counter values inside one nine-pulse byte
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // Positions inside the 16-bit data word
    localparam int RANGE_POS = 15;
    localparam int BUFFER_POS = 14;
    localparam int ZERO_POS = 13;
    localparam int SLEEP_POS = 12;
    // Position of the channel mask inside a queued entry
    localparam int MASK_POS = WORD_BITS;

    // Reset values
    localparam logic [4:0] SYNC_RST = 5'h03;
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
    localparam logic RANGE_RST = 1'b0;
    localparam logic BUFFER_RST = 1'b0;
    localparam logic GLOBAL_N_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WRITE,
        ST_READ,
        ST_IGNORE
    } qdsc_state_t;

endpackage : qdsc_pkg

// ==== qdsc_stream_if.sv ====
/*
 Valid/ready word carrier between the serial front end and the queue.
 Assumes source and sink share one clock.
*/
interface qdsc_stream_if #(parameter int WIDTH = 8) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : qdsc_stream_if

// ==== qdsc_fifo.sv ====
/*
 Flip-flop FIFO with valid/ready on both sides, honest full and empty.
 Assumes one clock and a synchronous active-high reset.
*/
module qdsc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    input wire logic clk, // Block clock
    input wire logic rst, // Synchronous reset
    qdsc_stream_if.snk wr_side, // Filling side
    qdsc_stream_if.src rd_side // Draining side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] wr_ptr_next;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] rd_ptr_next;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign wr_side.ready = !full;
    assign rd_side.valid = !empty;
    assign rd_side.data = mem_reg[rd_ptr_reg[AW-1:0]];
    assign push = wr_side.valid && !full;
    assign pop = rd_side.ready && !empty;

    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage needs no reset; entries are read only after being written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= wr_side.data;
        end
    end

endmodule : qdsc_fifo

// ==== qdsc_top.sv ====
/*
 Two-wire serial slave control for a quad voltage DAC: addressing, byte
 framing, pointer, write and readback, per-channel control and code
 registers, global clear and sleep. Assumes SCL, SDA and the straps are
 asynchronous pins, sampled at 100 MHz; the bus wire level is resolved
 outside from SDA_OE.
*/
module qdsc_top (
    input wire logic CLOCK, // 100 MHz block clock
    input wire logic RST, // Synchronous reset, active high
    input wire logic SCL, // Serial clock pin, input only
    input wire logic SDA_IN, // Serial data pin level
    output logic SDA_OUT, // Serial data drive value, always low
    output logic SDA_OE, // High while pulling SDA low
    input wire logic ADDR_STRAP_BIT0, // Address bit 0 strap
    input wire logic ADDR_STRAP_BIT1, // Address bit 1 strap
    input wire logic APPLY_HOLD, // High stalls applying queued words
    output logic [47:0] CHANNEL_CODE, // Codes, channel A in bits 11:0
    output logic [3:0] CHANNEL_DOUBLE_SPAN, // Per channel double span
    output logic [3:0] CHANNEL_REF_BUFFERED, // Per channel buffered reference
    output logic [3:0] CHANNEL_POWERED // Channel outputs active
);
    localparam int CB = qdsc_pkg::CODE_BITS;

    function automatic logic is_onehot(input logic [3:0] m);
        return (m != 4'h0) && ((m & (m - 4'h1)) == 4'h0);
    endfunction : is_onehot

    function automatic logic [1:0] onehot_idx(input logic [3:0] m);
        return m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
    endfunction : onehot_idx

    // Pin synchronisers: meta stage is read only by the stable stage
    logic [4:0] meta_reg;
    logic [4:0] meta_next;
    logic [4:0] stab_reg;
    logic [4:0] stab_next;
    logic [4:0] prev_reg;
    logic [4:0] prev_next;

    always_comb begin
        meta_next = {APPLY_HOLD, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0, SDA_IN, SCL};
        stab_next = meta_reg;
        prev_next = stab_reg;
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            meta_reg <= qdsc_pkg::SYNC_RST;
            stab_reg <= qdsc_pkg::SYNC_RST;
            prev_reg <= qdsc_pkg::SYNC_RST;
        end else begin
            meta_reg <= meta_next;
            stab_reg <= stab_next;
            prev_reg <= prev_next;
        end
    end

    logic scl_s;
    logic sda_s;
    logic hold_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_match;

    assign scl_s = stab_reg[0];
    assign sda_s = stab_reg[1];
    assign hold_s = stab_reg[4];
    assign scl_rise = scl_s && !prev_reg[0];
    assign scl_fall = !scl_s && prev_reg[0];
    assign start_det = scl_s && prev_reg[0] && !sda_s && prev_reg[1];
    assign stop_det = scl_s && prev_reg[0] && sda_s && !prev_reg[1];

    qdsc_stream_if #(.WIDTH(qdsc_pkg::FIFO_WIDTH)) wr_if ();
    qdsc_stream_if #(.WIDTH(qdsc_pkg::FIFO_WIDTH)) rd_if ();

    qdsc_fifo #(
        .WIDTH(qdsc_pkg::FIFO_WIDTH),
        .DEPTH(qdsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst(RST),
        .wr_side(wr_if.snk),
        .rd_side(rd_if.src)
    );

    // Channel and global state
    logic [CB-1:0] code_reg [4];
    logic [3:0] range_reg;
    logic [3:0] buffer_reg;
    logic zero_all_n_reg;
    logic zero_all_n_next;
    logic sleep_all_n_reg;
    logic sleep_all_n_next;
    logic [qdsc_pkg::FIFO_WIDTH-1:0] word;
    logic fire;
    logic [15:0] rd_word;

    // Serial front end state
    qdsc_pkg::qdsc_state_t state_reg;
    qdsc_pkg::qdsc_state_t state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [3:0] ptr_mask_reg;
    logic [3:0] ptr_mask_next;
    logic oe_reg;
    logic oe_next;
    logic rw_reg;
    logic rw_next;
    logic wr_lo_reg;
    logic wr_lo_next;
    logic rd_lo_reg;
    logic rd_lo_next;
    logic mack_reg;
    logic mack_next;
    logic armed_reg;
    logic armed_next;
    logic push_reg;
    logic push_next;
    logic [qdsc_pkg::FIFO_WIDTH-1:0] push_data_reg;
    logic [qdsc_pkg::FIFO_WIDTH-1:0] push_data_next;

    assign addr_match = (shift_reg[7:1] == {qdsc_pkg::SLAVE_ADDR_HI, stab_reg[3], stab_reg[2]});
    assign rd_word = is_onehot(ptr_mask_reg) ?
        {range_reg[onehot_idx(ptr_mask_reg)], buffer_reg[onehot_idx(ptr_mask_reg)],
         zero_all_n_reg, sleep_all_n_reg, code_reg[onehot_idx(ptr_mask_reg)]} :
        {2'h0, zero_all_n_reg, sleep_all_n_reg, qdsc_pkg::CODE_RST};

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        hi_next = hi_reg;
        ptr_mask_next = ptr_mask_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        wr_lo_next = wr_lo_reg;
        rd_lo_next = rd_lo_reg;
        mack_next = mack_reg;
        armed_next = armed_reg;
        push_next = 1'b0;
        push_data_next = push_data_reg;
        if (start_det) begin
            state_next = qdsc_pkg::ST_ADDR;
            bit_cnt_next = 4'h0;
            oe_next = 1'b0;
            armed_next = 1'b0;
        end else if (stop_det) begin
            state_next = qdsc_pkg::ST_IDLE;
            bit_cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (state_reg != qdsc_pkg::ST_IDLE && state_reg != qdsc_pkg::ST_IGNORE) begin
            if (scl_rise) begin
                armed_next = 1'b1;
                if (bit_cnt_reg < qdsc_pkg::BIT_ACK) begin
                    shift_next = {shift_reg[6:0], sda_s};
                end else begin
                    mack_next = !sda_s;
                end
            end
            // The fall that closes a start carries no bit, so it must not count
            if (scl_fall && armed_reg) begin
                if (bit_cnt_reg == qdsc_pkg::BIT_ACK) begin
                    bit_cnt_next = 4'h0;
                    oe_next = 1'b0;
                    unique case (state_reg)
                        qdsc_pkg::ST_ADDR: begin
                            if (rw_reg) begin
                                state_next = qdsc_pkg::ST_READ;
                                tx_next = rd_word[15:8];
                                oe_next = !rd_word[15];
                                rd_lo_next = 1'b1;
                            end else begin
                                state_next = qdsc_pkg::ST_PTR;
                            end
                        end
                        qdsc_pkg::ST_PTR: state_next = qdsc_pkg::ST_WRITE;
                        qdsc_pkg::ST_WRITE: state_next = qdsc_pkg::ST_WRITE;
                        qdsc_pkg::ST_READ: begin
                            if (mack_reg) begin
                                tx_next = rd_lo_reg ? rd_word[7:0] : rd_word[15:8];
                                oe_next = rd_lo_reg ? !rd_word[7] : !rd_word[15];
                                rd_lo_next = !rd_lo_reg;
                            end else begin
                                state_next = qdsc_pkg::ST_IGNORE;
                            end
                        end
                        default: state_next = qdsc_pkg::ST_IDLE;
                    endcase
                end else begin
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == qdsc_pkg::BIT_LAST) begin
                        oe_next = 1'b0;
                        unique case (state_reg)
                            qdsc_pkg::ST_ADDR: begin
                                if (addr_match) begin
                                    oe_next = 1'b1;
                                    rw_next = shift_reg[0];
                                end else begin
                                    state_next = qdsc_pkg::ST_IGNORE;
                                end
                            end
                            qdsc_pkg::ST_PTR: begin
                                oe_next = 1'b1;
                                ptr_mask_next = shift_reg[3:0];
                                wr_lo_next = 1'b0;
                            end
                            qdsc_pkg::ST_WRITE: begin
                                if (!wr_lo_reg) begin
                                    hi_next = shift_reg;
                                    wr_lo_next = 1'b1;
                                    oe_next = 1'b1;
                                end else begin
                                    wr_lo_next = 1'b0;
                                    if (ptr_mask_reg == 4'h0) begin
                                        oe_next = 1'b1;
                                    end else if (wr_if.ready) begin
                                        // Full queue refuses the byte with a no-acknowledge
                                        oe_next = 1'b1;
                                        push_next = 1'b1;
                                        push_data_next = {ptr_mask_reg, hi_reg, shift_reg};
                                    end
                                end
                            end
                            qdsc_pkg::ST_READ: oe_next = 1'b0;
                            default: state_next = qdsc_pkg::ST_IDLE;
                        endcase
                    end else if (state_reg == qdsc_pkg::ST_READ) begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = !tx_reg[6];
                    end
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= qdsc_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            hi_reg <= 8'h00;
            ptr_mask_reg <= qdsc_pkg::PTR_RST;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            wr_lo_reg <= 1'b0;
            rd_lo_reg <= 1'b0;
            mack_reg <= 1'b0;
            armed_reg <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= '0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            hi_reg <= hi_next;
            ptr_mask_reg <= ptr_mask_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            wr_lo_reg <= wr_lo_next;
            rd_lo_reg <= rd_lo_next;
            mack_reg <= mack_next;
            armed_reg <= armed_next;
            push_reg <= push_next;
            push_data_reg <= push_data_next;
        end
    end

    assign wr_if.valid = push_reg;
    assign wr_if.data = push_data_reg;
    assign rd_if.ready = !hold_s;
    assign fire = rd_if.valid && rd_if.ready;
    assign word = rd_if.data;

    // Global clear and sleep state
    always_comb begin
        zero_all_n_next = zero_all_n_reg;
        sleep_all_n_next = sleep_all_n_reg;
        if (fire) begin
            zero_all_n_next = word[qdsc_pkg::ZERO_POS];
            sleep_all_n_next = word[qdsc_pkg::SLEEP_POS];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            zero_all_n_reg <= qdsc_pkg::GLOBAL_N_RST;
            sleep_all_n_reg <= qdsc_pkg::GLOBAL_N_RST;
        end else begin
            zero_all_n_reg <= zero_all_n_next;
            sleep_all_n_reg <= sleep_all_n_next;
        end
    end

    for (genvar ch = 0; ch < qdsc_pkg::CHANNELS; ch++) begin : g_ch
        logic [CB-1:0] code_next;
        logic range_next;
        logic buffer_next;

        always_comb begin
            code_next = code_reg[ch];
            range_next = range_reg[ch];
            buffer_next = buffer_reg[ch];
            if (fire && word[qdsc_pkg::MASK_POS+ch]) begin
                range_next = word[qdsc_pkg::RANGE_POS];
                buffer_next = word[qdsc_pkg::BUFFER_POS];
                code_next = word[CB-1:0];
            end
            if (fire && !word[qdsc_pkg::ZERO_POS]) begin
                code_next = qdsc_pkg::CODE_RST;
            end
        end

        always_ff @(posedge CLOCK) begin
            if (RST) begin
                code_reg[ch] <= qdsc_pkg::CODE_RST;
                range_reg[ch] <= qdsc_pkg::RANGE_RST;
                buffer_reg[ch] <= qdsc_pkg::BUFFER_RST;
            end else begin
                code_reg[ch] <= code_next;
                range_reg[ch] <= range_next;
                buffer_reg[ch] <= buffer_next;
            end
        end

        assign CHANNEL_CODE[ch*CB +: CB] = code_reg[ch];
        assign CHANNEL_POWERED[ch] = sleep_all_n_reg;
    end

    assign CHANNEL_DOUBLE_SPAN = range_reg;
    assign CHANNEL_REF_BUFFERED = buffer_reg;
    assign SDA_OE = oe_reg;
    assign SDA_OUT = 1'b0;

    addr_ack_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_reg == qdsc_pkg::ST_ADDR && scl_fall && !start_det && !stop_det &&
         bit_cnt_reg == qdsc_pkg::BIT_LAST && addr_match) |=> oe_reg)
        else $error("Matching address not acknowledged");
    ignore_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_reg == qdsc_pkg::ST_IGNORE && $past(state_reg == qdsc_pkg::ST_IGNORE)) |-> !oe_reg)
        else $error("SDA driven while ignoring the bus");
    sda_timing_a: assert property (@(posedge CLOCK) disable iff (RST)
        $changed(oe_reg) |-> $past(scl_fall || start_det || stop_det))
        else $error("SDA changed outside SCL low");
    nine_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
        bit_cnt_reg <= qdsc_pkg::BIT_ACK)
        else $error("Bit counter beyond acknowledge slot");
    ptr_load_a: assert property (@(posedge CLOCK) disable iff (RST)
        $changed(ptr_mask_reg) |-> $past(state_reg == qdsc_pkg::ST_PTR && scl_fall &&
            bit_cnt_reg == qdsc_pkg::BIT_LAST))
        else $error("Pointer changed outside pointer byte");
    empty_ptr_a: assert property (@(posedge CLOCK) disable iff (RST)
        push_reg |-> $past(ptr_mask_reg) != 4'h0)
        else $error("Word queued for empty pointer");
    reset_state_a: assert property (@(posedge CLOCK) disable iff (RST)
        $past(RST) |-> (CHANNEL_CODE == 48'h0 && CHANNEL_DOUBLE_SPAN == 4'h0 &&
            CHANNEL_REF_BUFFERED == 4'h0 && CHANNEL_POWERED == 4'hf))
        else $error("Wrong state after reset");
    clear_all_a: assert property (@(posedge CLOCK) disable iff (RST)
        (fire && !word[qdsc_pkg::ZERO_POS]) |=> CHANNEL_CODE == 48'h0)
        else $error("Clear did not zero codes");
    multi_read_a: assert property (@(posedge CLOCK) disable iff (RST)
        !is_onehot(ptr_mask_reg) |-> (rd_word[15:14] == 2'h0 && rd_word[11:0] == 12'h000))
        else $error("Multi-channel readback not zero");
    load_sel_a: assert property (@(posedge CLOCK) disable iff (RST)
        (fire && word[qdsc_pkg::ZERO_POS] && word[qdsc_pkg::MASK_POS]) |=>
            CHANNEL_CODE[11:0] == $past(word[11:0]))
        else $error("Selected channel A not loaded");

endmodule : qdsc_top

// ==== qdsc_bus_master.sv ====
/*
 Behavioural two-wire bus master: drives SCL, pulls SDA low.
 Assumes the bench resolves SDA with a pull-up from every pull.
*/
module qdsc_bus_master (
    output logic scl, // Bus clock, idle high
    output logic sda_pull, // High while pulling SDA low
    input wire logic sda_wire, // Resolved SDA level
    input wire logic slow // Stretches the low phase of every clocked bit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // SDA moves only mid-low, so the device answer settles before the rise
    task automatic clk_bit(input logic b, output logic s);
        #30;
        if (slow) #200;
        sda_pull = ~b;
        #32.5 scl = 1'b1;
        #31.25 s = sda_wire;
        #31.25 scl = 1'b0;
    endtask : clk_bit
    task automatic start_cond();
        if (!scl) begin
            #30 sda_pull = 1'b0;
            #32.5 scl = 1'b1;
        end
        #30 sda_pull = 1'b1;
        #32.5 scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #30 sda_pull = 1'b1;
        #32.5 scl = 1'b1;
        #30 sda_pull = 1'b0;
        #32.5;
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte
    task automatic take_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(~ack, s);
    endtask : take_byte
endmodule : qdsc_bus_master

// ==== quad_dac_serial_control_tb_top.sv ====
/*
 Self-checking bench: writes, readbacks, sleep, clear and queue overflow.
 Assumes qdsc_top and the bus master model; SDA has a pull-up.
*/
module quad_dac_serial_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic [1:0] straps = 2'b10;
    logic scl, sda_pull, sda_oe, sda_out;
    logic [47:0] code;
    logic [3:0] span, bufd, powered;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] rptr[5] = '{8'h01, 8'h02, 8'h04, 8'h0c, 8'h08};
    logic [15:0] rexp[5] = '{16'hbabc, 16'h3000, 16'h7123, 16'h3000, 16'h7123};
    // Pull-up unless either side pulls; the device pulls to its drive value
    wire logic sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

    qdsc_top dut (.CLOCK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDR_STRAP_BIT0(straps[0]), .ADDR_STRAP_BIT1(straps[1]),
        .APPLY_HOLD(hold), .CHANNEL_CODE(code), .CHANNEL_DOUBLE_SPAN(span),
        .CHANNEL_REF_BUFFERED(bufd), .CHANNEL_POWERED(powered));
    qdsc_bus_master master (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire), .slow(slow));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // Returns how many bytes were acknowledged and the last acknowledge
    task automatic write_words(input logic [6:0] addr, input logic [7:0] ptr,
                               input logic [15:0] w[$], output logic [7:0] n,
                               output logic a);
        master.start_cond();
        master.send_byte({addr, 1'b0}, a);
        n = {7'h00, a};
        master.send_byte(ptr, a);
        n = n + {7'h00, a};
        foreach (w[i]) begin
            master.send_byte(w[i][15:8], a);
            n = n + {7'h00, a};
            master.send_byte(w[i][7:0], a);
            n = n + {7'h00, a};
        end
        master.stop_cond();
        repeat (20) @(posedge clk);
    endtask : write_words

    task automatic read_word(input logic use_ptr, input logic [7:0] ptr,
                             output logic [15:0] w);
        logic a;
        if (use_ptr) begin
            master.start_cond();
            master.send_byte(8'h1c, a);
            master.send_byte(ptr, a);
        end
        master.start_cond();
        master.send_byte(8'h1d, a);
        master.take_byte(1'b1, w[15:8]);
        master.take_byte(1'b0, w[7:0]);
        master.stop_cond();
        repeat (5) @(posedge clk);
    endtask : read_word

    initial begin
        logic [7:0] n;
        logic last;
        logic [15:0] rd;
        logic [15:0] q[$];
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        check({code, span, bufd, powered}, {48'h0, 12'h00f});
        q = {16'hbabc};
        write_words(7'h5a, 8'h01, q, n, last);
        check(n, 8'h00);
        write_words(7'h0d, 8'h01, q, n, last);
        check({n, code}, {8'h00, 48'h0});
        write_words(7'h0e, 8'hc1, q, n, last);
        check({n, code, span, bufd}, {8'h04, 48'habc, 8'h10});
        slow <= 1'b1;
        q = {16'h7123};
        write_words(7'h0e, 8'h0c, q, n, last);
        slow <= 1'b0;
        check({code, span, bufd}, {48'h123123000abc, 8'h1c});
        straps <= 2'b01;
        repeat (4) @(posedge clk);
        q = {16'hbfff};
        write_words(7'h0d, 8'h00, q, n, last);
        check({n, code, span, bufd}, {8'h04, 48'h123123000abc, 8'h1c});
        straps <= 2'b10;
        repeat (4) @(posedge clk);
        foreach (rptr[i]) begin
            read_word(1'b1, rptr[i], rd);
            check(rd, rexp[i]);
        end
        read_word(1'b0, 8'h00, rd);
        check(rd, 16'h7123);
        q = {16'ha055};
        write_words(7'h0e, 8'h01, q, n, last);
        check({code, span, powered}, {48'h123123000055, 8'h10});
        q = {16'h9123};
        write_words(7'h0e, 8'h02, q, n, last);
        check({code, span, powered}, {48'h0, 8'h3f});
        // Held queue takes 32 words, then refuses the low byte of the next
        hold <= 1'b1;
        q.delete();
        for (int i = 0; i < 33; i++) q.push_back(16'h3000 | 16'(i));
        write_words(7'h0e, 8'h08, q, n, last);
        check({n, last, code}, {8'h43, 1'b0, 48'h0});
        hold <= 1'b0;
        repeat (60) @(posedge clk);
        check({code, span, bufd}, {48'h01f000000000, 8'h34});
        test_done();
    end

    initial begin
        #1ms;
        miscompares++;
        test_done();
    end
endmodule : quad_dac_serial_control_tb_top
